// ==== verilog/uart_wm_pkg.sv ====
// Purpose: Shared constants and types for the UART watermark and baud block
// Assumes: 100 MHz bus clock, AHB-Lite word access
// Notes:   Offsets are byte addresses of aligned 32-bit registers
package uart_wm_pkg;

  // ----------------------------------------------------------------------
  // Clock and line rate
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned BAUD_HZ = 115200;
  // Stored divisor is the divide ratio minus one
  localparam logic [15:0] DIV_INIT =
    16'((CLK_HZ + BAUD_HZ / 2) / BAUD_HZ - 1);

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_TXCTRL = 8'h08;
  localparam logic [7:0] OFS_RXCTRL = 8'h0c;
  localparam logic [7:0] OFS_IRQ_EN = 8'h10;
  localparam logic [7:0] OFS_IRQ_PEND = 8'h14;
  localparam logic [7:0] OFS_DIV = 8'h18;
  localparam logic [7:0] OFS_EVT = 8'h1c;
  localparam logic [7:0] OFS_EVT_MASK = 8'h20;

  // ----------------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------------
  localparam int TXEN_BIT = 0;
  localparam int NSTOP_BIT = 1;
  localparam int RXEN_BIT = 0;
  localparam int CNT_LSB = 16;
  localparam int CNT_MSB = 18;
  localparam int WM_TX_BIT = 0;
  localparam int WM_RX_BIT = 1;
  localparam int DIV_MSB = 15;
  localparam logic [1:0] WM_RST = 2'h0;
  localparam logic [2:0] CNT_RST = 3'h0;

  // ----------------------------------------------------------------------
  // Queues and oversampling
  // ----------------------------------------------------------------------
  localparam int QCNT_W = 4;
  localparam logic [3:0] QDEPTH = 4'h8;
  localparam int OSR_SHIFT = 4;
  localparam logic [3:0] VOTE_PHASE = 4'h9;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [QCNT_W-1:0] tx_count;
    logic [QCNT_W-1:0] rx_count;
  } queue_level_t;

  typedef struct packed {
    logic txen;
    logic nstop;
    logic rxen;
  } line_ctrl_t;

  typedef enum logic [1:0] {
    DP_IDLE = 2'b00,
    DP_READ = 2'b01,
    DP_WRITE = 2'b10
  } dphase_t;

endpackage

// ==== verilog/uart_watermark_irq_baud_gen.sv ====
// Purpose: UART watermark interrupts and shared baud rate generation
// Assumes: Queue occupancy counts arrive on the bus clock
// Notes:   AHB-Lite slave with zero wait states, always OKAY
//
// Design decision made here: the AHB-Lite register port.
`timescale 1ns/1ps

module uart_watermark_irq_baud_gen
  import uart_wm_pkg::*;
#(
  parameter logic [15:0] DIV_RESET = DIV_INIT
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Queue occupancy from the rest of the UART
  input wire queue_level_t qlevel,
  // Serial line and character framing
  input wire logic rxd,
  input wire logic rx_realign,
  // Control and timing to the framers
  output line_ctrl_t line_ctrl,
  output logic tx_baud_tick,
  output logic rx_bit_strobe,
  output logic rx_bit_value,
  // Interrupt
  output logic irq
);

  // ----------------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------------
  function automatic logic [2:0] cnt_field(input logic [31:0] w);
    cnt_field = w[CNT_MSB:CNT_LSB];
  endfunction

  function automatic logic majority3(input logic [2:0] s);
    majority3 = (s[0] & s[1]) | (s[1] & s[2]) | (s[0] & s[2]);
  endfunction

  function automatic logic [3:0] clamp_q(input logic [3:0] c);
    clamp_q = (c > QDEPTH) ? QDEPTH : c;
  endfunction

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  dphase_t dphase_ff;
  logic [ADDR_W-1:0] addr_ff;
  logic [31:0] rdata_ff;
  logic txen_ff;
  logic nstop_ff;
  logic rxen_ff;
  logic [2:0] txcnt_ff;
  logic [2:0] rxcnt_ff;
  logic [1:0] wm_en_ff;
  logic [1:0] wm_pend_ff;
  logic [1:0] evt_ff;
  logic [1:0] evt_mask_ff;
  logic [15:0] div_ff;
  logic irq_ff;

  logic [1:0] nxt_wm_pend;
  logic [31:0] nxt_rdata;
  logic addr_take;
  logic wr_now;
  logic div_wr;
  logic [3:0] tx_level;
  logic [3:0] rx_level;

  // ----------------------------------------------------------------------
  // Bus address phase
  // ----------------------------------------------------------------------
  assign addr_take = hsel & hready & htrans[1];
  assign wr_now = (dphase_ff == DP_WRITE);
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_ff;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dphase_ff <= DP_IDLE;
      addr_ff <= '0;
    end else if (hready) begin
      if (addr_take) begin
        dphase_ff <= hwrite ? DP_WRITE : DP_READ;
        addr_ff <= haddr[ADDR_W-1:0];
      end else begin
        dphase_ff <= DP_IDLE;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Read data, captured in the address phase
  // ----------------------------------------------------------------------
  always_comb begin
    nxt_rdata = '0;
    case (haddr[ADDR_W-1:0])
      OFS_TXCTRL: begin
        nxt_rdata[TXEN_BIT] = txen_ff;
        nxt_rdata[NSTOP_BIT] = nstop_ff;
        nxt_rdata[CNT_MSB:CNT_LSB] = txcnt_ff;
      end
      OFS_RXCTRL: begin
        nxt_rdata[RXEN_BIT] = rxen_ff;
        nxt_rdata[CNT_MSB:CNT_LSB] = rxcnt_ff;
      end
      OFS_IRQ_EN: nxt_rdata[1:0] = wm_en_ff;
      OFS_IRQ_PEND: nxt_rdata[1:0] = wm_pend_ff;
      OFS_DIV: nxt_rdata[DIV_MSB:0] = div_ff;
      OFS_EVT: nxt_rdata[1:0] = evt_ff;
      OFS_EVT_MASK: nxt_rdata[1:0] = evt_mask_ff;
      default: nxt_rdata = '0;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_ff <= '0;
    end else if (addr_take && !hwrite) begin
      rdata_ff <= nxt_rdata;
    end
  end

  // ----------------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      txen_ff <= 1'b0;
      nstop_ff <= 1'b0;
      txcnt_ff <= CNT_RST;
    end else if (wr_now && addr_ff == OFS_TXCTRL) begin
      txen_ff <= hwdata[TXEN_BIT];
      nstop_ff <= hwdata[NSTOP_BIT];
      txcnt_ff <= cnt_field(hwdata);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rxen_ff <= 1'b0;
      rxcnt_ff <= CNT_RST;
    end else if (wr_now && addr_ff == OFS_RXCTRL) begin
      rxen_ff <= hwdata[RXEN_BIT];
      rxcnt_ff <= cnt_field(hwdata);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wm_en_ff <= WM_RST;
    end else if (wr_now && addr_ff == OFS_IRQ_EN) begin
      wm_en_ff <= hwdata[1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      evt_mask_ff <= WM_RST;
    end else if (wr_now && addr_ff == OFS_EVT_MASK) begin
      evt_mask_ff <= hwdata[1:0];
    end
  end

  assign div_wr = wr_now && (addr_ff == OFS_DIV);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_ff <= DIV_RESET;
    end else if (div_wr) begin
      div_ff <= hwdata[DIV_MSB:0];
    end
  end

  assign line_ctrl = '{txen: txen_ff, nstop: nstop_ff, rxen: rxen_ff};

  // ----------------------------------------------------------------------
  // Watermark conditions
  // ----------------------------------------------------------------------
  assign tx_level = clamp_q(qlevel.tx_count);
  assign rx_level = clamp_q(qlevel.rx_count);

  always_comb begin
    nxt_wm_pend[WM_TX_BIT] = tx_level < {1'b0, txcnt_ff};
    nxt_wm_pend[WM_RX_BIT] = rx_level > {1'b0, rxcnt_ff};
  end

  // Pending tracks live levels every cycle, never latched
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wm_pend_ff <= WM_RST;
    end else begin
      wm_pend_ff <= nxt_wm_pend;
    end
  end

  // Sticky event on each rising condition; set beats clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      evt_ff <= WM_RST;
    end else if (wr_now && addr_ff == OFS_EVT) begin
      evt_ff <= (evt_ff & ~hwdata[1:0]) | (nxt_wm_pend & ~wm_pend_ff);
    end else begin
      evt_ff <= evt_ff | (nxt_wm_pend & ~wm_pend_ff);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(nxt_wm_pend & wm_en_ff) | |(evt_ff & evt_mask_ff);
    end
  end

  assign irq = irq_ff;

  // ----------------------------------------------------------------------
  // Transmit bit rate
  // ----------------------------------------------------------------------
  logic [15:0] tx_div_ff;
  logic tx_tick_ff;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_div_ff <= '0;
      tx_tick_ff <= 1'b0;
    end else if (div_wr) begin
      tx_div_ff <= '0;
      tx_tick_ff <= 1'b0;
    end else if (tx_div_ff >= div_ff) begin
      tx_div_ff <= '0;
      tx_tick_ff <= 1'b1;
    end else begin
      tx_div_ff <= tx_div_ff + 16'h0001;
      tx_tick_ff <= 1'b0;
    end
  end

  assign tx_baud_tick = tx_tick_ff;

  // ----------------------------------------------------------------------
  // Receive oversampling
  // ----------------------------------------------------------------------
  logic rxd_meta_ff;
  logic rxd_sync_ff;
  logic [15:0] os_lim;
  logic [15:0] os_cnt_ff;
  logic os_tick;
  logic [3:0] phase_ff;
  logic [1:0] smp_ff;
  logic strobe_ff;
  logic value_ff;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rxd_meta_ff <= 1'b1;
      rxd_sync_ff <= 1'b1;
    end else begin
      rxd_meta_ff <= rxd;
      rxd_sync_ff <= rxd_meta_ff;
    end
  end

  // Sixteen sample ticks per bit; ratios under sixteen tick every cycle
  assign os_lim = ((div_ff + 16'h0001) >> OSR_SHIFT) - 16'h0001;
  assign os_tick = rxen_ff && (os_cnt_ff >= os_lim || os_lim == 16'hffff);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      os_cnt_ff <= '0;
    end else if (!rxen_ff || rx_realign || div_wr || os_tick) begin
      os_cnt_ff <= '0;
    end else begin
      os_cnt_ff <= os_cnt_ff + 16'h0001;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_ff <= '0;
      smp_ff <= '1;
    end else if (!rxen_ff || rx_realign) begin
      phase_ff <= '0;
      smp_ff <= '1;
    end else if (os_tick) begin
      phase_ff <= phase_ff + 4'h1;
      smp_ff <= {smp_ff[0], rxd_sync_ff};
    end
  end

  // Vote over the three samples ending at the vote phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      strobe_ff <= 1'b0;
      value_ff <= 1'b1;
    end else if (os_tick && phase_ff == VOTE_PHASE && !rx_realign) begin
      strobe_ff <= 1'b1;
      value_ff <= majority3({smp_ff, rxd_sync_ff});
    end else begin
      strobe_ff <= 1'b0;
    end
  end

  assign rx_bit_strobe = strobe_ff;
  assign rx_bit_value = value_ff;

endmodule

// ==== tb/uart_wm_asserts.sv ====
// Purpose: Port checks for the watermark and baud block
// Assumes: One slave, hready tied to hreadyout
// Notes:   Enable, event mask and divisor are shadowed from bus writes
`timescale 1ns/1ps
module uart_wm_asserts
  import uart_wm_pkg::*;
#(
  parameter logic [15:0] DIV_RESET = DIV_INIT
) (
  // Bus
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // Line and interrupt
  input wire line_ctrl_t line_ctrl,
  input wire logic tx_baud_tick,
  input wire logic rx_bit_strobe,
  input wire logic rx_bit_value,
  input wire logic irq
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  logic wr_ff, seen_ff, take, div_wr;
  logic [7:0] a_ff;
  logic [1:0] en_ff;
  logic [1:0] mk_ff;
  logic [15:0] div_ff;
  logic [16:0] cnt_ff;
  assign take = hsel && hready && htrans[1];
  assign div_wr = wr_ff && a_ff == OFS_DIV;

  // ----------
  // Shadows
  // ----------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ff <= 1'b0;
      a_ff <= 8'h00;
      en_ff <= 2'h0;
      mk_ff <= 2'h0;
      div_ff <= DIV_RESET;
    end else begin
      wr_ff <= take && hwrite;
      a_ff <= haddr[7:0];
      if (wr_ff && a_ff == OFS_IRQ_EN) begin
        en_ff <= hwdata[1:0];
      end
      if (wr_ff && a_ff == OFS_EVT_MASK) begin
        mk_ff <= hwdata[1:0];
      end
      if (div_wr) begin
        div_ff <= hwdata[15:0];
      end
    end
  end

  // Cycles since last tick; a divisor write voids the period
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_ff <= 17'h0;
      seen_ff <= 1'b0;
    end else begin
      cnt_ff <= tx_baud_tick ? 17'h0 : cnt_ff + 17'h1;
      seen_ff <= !div_wr && (tx_baud_tick || seen_ff);
    end
  end

  a_resp_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  a_tick_period: assert property (
    tx_baud_tick && seen_ff |-> cnt_ff == {1'b0, div_ff})
    else $error("baud tick period wrong");
  a_tick_single: assert property (
    tx_baud_tick |=> !tx_baud_tick)
    else $error("baud tick longer than one cycle");
  a_strobe_gap: assert property (
    rx_bit_strobe |=> !rx_bit_strobe [*8])
    else $error("bit strobes too close");
  a_value_hold: assert property (
    !rx_bit_strobe |-> $stable(rx_bit_value))
    else $error("bit value moved without strobe");
  a_rx_idle: assert property (
    !line_ctrl.rxen [*2] |-> !rx_bit_strobe)
    else $error("strobe while receiver off");
  a_irq_masked: assert property (
    $past(en_ff) == 2'h0 && $past(mk_ff) == 2'h0 |-> !irq)
    else $error("interrupt with nothing enabled");
  a_rdata_hold: assert property (
    !$past(take && !hwrite) |-> $stable(hrdata))
    else $error("read data moved without a read");
endmodule

bind uart_watermark_irq_baud_gen uart_wm_asserts #(
  .DIV_RESET(DIV_RESET)
) chk_i (
  .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
  .hrdata, .hreadyout, .hresp, .line_ctrl, .tx_baud_tick,
  .rx_bit_strobe, .rx_bit_value, .irq
);

// ==== tb/uart_line_model.sv ====
// Purpose: Remote transceiver driving the receive line
// Assumes: Line idles high between characters
// Notes:   Optional two-cycle glitch inside every bit
`timescale 1ns/1ps
module uart_line_model (
  // Clock
  input wire logic hclk,
  // Line
  output logic rxd
);
  initial rxd = 1'b1;

  // Start, eight data bits lsb first, one stop
  task automatic send(input logic [7:0] d, input int ratio,
                      input logic glitch);
    logic [9:0] f;
    f = {1'b1, d, 1'b0};
    for (int b = 0; b < 10; b++) begin
      for (int c = 0; c < ratio; c++) begin
        rxd <= f[b] ^ (glitch && (c == 14 || c == 15));
        @(posedge hclk);
      end
    end
  endtask
endmodule

// ==== tb/uart_watermark_irq_baud_gen_tb.sv ====
// Purpose: Self-checking bench for the watermark and baud block
// Assumes: Zero-wait bus slave, 100 MHz clock
// Notes:   Line model supplies receive frames
`timescale 1ns/1ps
module uart_watermark_irq_baud_gen_tb;
  import uart_wm_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, rxd, irq;
  logic rx_realign, tx_baud_tick, rx_bit_strobe, rx_bit_value;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, r;
  queue_level_t qlevel;
  line_ctrl_t line_ctrl;
  int miscompares, n_tests;

  uart_watermark_irq_baud_gen uut (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .qlevel, .rxd,
    .rx_realign, .line_ctrl, .tx_baud_tick, .rx_bit_strobe,
    .rx_bit_value, .irq
  );
  uart_line_model line (.hclk, .rxd);

  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic [7:0] a, input logic w,
                     input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(a, 1'b0, 32'h0);
    chk(r, e);
  endtask

  task automatic irq_is(input logic e);
    repeat (2) @(negedge hclk);
    chk({31'h0, irq}, {31'h0, e});
  endtask

  task automatic t_reset;
    rd(OFS_IRQ_EN, 32'h0);
    rd(OFS_DIV, 32'h0000_0363);
    rd(OFS_TXCTRL, 32'h0);
    rd(OFS_RXCTRL, 32'h0);
    bus(OFS_IRQ_EN, 1'b1, 32'hffff_fffc);
    rd(OFS_IRQ_EN, 32'h0);
    bus(OFS_IRQ_PEND, 1'b1, 32'h3);
    rd(OFS_IRQ_PEND, 32'h0);
    rd(8'h2c, 32'h0);
    bus(OFS_TXCTRL, 1'b1, 32'h0007_0003);
    rd(OFS_TXCTRL, 32'h0007_0003);
    chk({29'h0, line_ctrl}, {29'h0, 3'b110});
    $display("reset test done");
  endtask

  task automatic t_wm;
    bus(OFS_TXCTRL, 1'b1, 32'h0003_0000);
    bus(OFS_RXCTRL, 1'b1, 32'h0005_0000);
    for (int i = 0; i <= 8; i++) begin
      qlevel <= {4'(i), 4'(i)};
      rd(OFS_IRQ_PEND, {30'h0, i > 5, i < 3});
    end
    qlevel <= {4'h4, 4'h4};
    bus(OFS_TXCTRL, 1'b1, 32'h0005_0000);
    rd(OFS_IRQ_PEND, 32'h1);
    bus(OFS_RXCTRL, 1'b1, 32'h0003_0000);
    rd(OFS_IRQ_PEND, 32'h3);
    qlevel <= {4'h4, 4'h3};
    rd(OFS_IRQ_PEND, 32'h1);
    $display("watermark test done");
  endtask

  task automatic t_irq;
    bus(OFS_IRQ_EN, 1'b1, 32'h1);
    irq_is(1'b1);
    rd(OFS_IRQ_EN, 32'h1);
    qlevel <= {4'h5, 4'h3};
    irq_is(1'b0);
    bus(OFS_IRQ_EN, 1'b1, 32'h2);
    qlevel <= {4'h5, 4'h4};
    irq_is(1'b1);
    bus(OFS_IRQ_EN, 1'b1, 32'h0);
    irq_is(1'b0);
    rd(OFS_EVT, 32'h3);
    bus(OFS_EVT_MASK, 1'b1, 32'h1);
    irq_is(1'b1);
    bus(OFS_EVT, 1'b1, 32'h3);
    irq_is(1'b0);
    rd(OFS_EVT, 32'h0);
    rd(OFS_EVT_MASK, 32'h1);
    bus(OFS_EVT_MASK, 1'b1, 32'h0);
    $display("interrupt test done");
  endtask

  task automatic t_baud;
    int n;
    bus(OFS_DIV, 1'b1, 32'hffff_001f);
    rd(OFS_DIV, 32'h0000_001f);
    n = 0;
    do @(negedge hclk); while (tx_baud_tick !== 1'b1);
    do begin
      @(negedge hclk);
      n++;
    end while (tx_baud_tick !== 1'b1);
    chk(32'(n), 32'd32);
    $display("baud test done");
  endtask

  task automatic t_rx;
    logic [9:0] bits;
    logic [7:0] d;
    bus(OFS_RXCTRL, 1'b1, 32'h0003_0001);
    rd(OFS_RXCTRL, 32'h0003_0001);
    chk({29'h0, line_ctrl}, {29'h0, 3'b001});
    for (int k = 0; k < 2; k++) begin
      d = k ? 8'h3c : 8'ha5;
      @(posedge hclk);
      fork
        line.send(d, 32, k == 1);
        begin
          rx_realign <= 1'b1;
          @(posedge hclk);
          rx_realign <= 1'b0;
        end
      join_none
      repeat (10) begin
        do @(negedge hclk); while (rx_bit_strobe !== 1'b1);
        bits = {rx_bit_value, bits[9:1]};
      end
      chk({22'h0, bits}, {22'h0, 1'b1, d, 1'b0});
      wait fork;
    end
    $display("receive test done");
  endtask

  task automatic test_done;
    $display("%0d compares, %0d mismatches", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    repeat (6000) @(posedge hclk);
    miscompares++;
    test_done();
  end

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    qlevel = '0;
    rx_realign = 1'b0;
    miscompares = 0;
    n_tests = 0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_wm();
    t_irq();
    t_baud();
    t_rx();
    test_done();
  end
endmodule
